/* File: ivp_unit.sv */
// Interrupt prioritisation and vector offset generation
`timescale 1ns/1ps
`include "ivp_defines.svh"

module ivp_unit (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic reset_req,
    input wire logic nmi_irq,
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    input wire logic ext_irq_pin_two,
    input wire logic ext_irq_pin_three,
    input wire logic watchdog_irq,
    input wire logic wdt_gp_mode,
    input wire logic timer_zero_irq,
    input wire logic timer_one_irq,
    input wire logic serial_zero_rx_irq,
    input wire logic serial_zero_tx_irq,
    input wire logic serial_one_rx_irq,
    input wire logic serial_one_tx_irq,
    input wire logic serial_two_rx_irq,
    input wire logic serial_two_tx_irq,
    input wire logic dma_zero_irq,
    input wire logic dma_one_irq,
    input wire logic dma_two_irq,
    input wire logic dma_three_irq,
    input wire logic dma_four_irq,
    input wire logic dma_five_irq,
    input wire logic pll_lock_irq,
    input wire logic host_irq,
    input wire logic two_wire_bus_irq,
    input wire logic bus_error_irq,
    input wire logic data_log_irq,
    input wire logic rtos_irq,
    input wire logic software_trap,
    input wire ivp_pkg::ivp_slot_t software_trap_num,
    input wire ivp_pkg::ivp_vec_t irq_enable,
    input wire logic global_enable,
    input wire logic int_ack,
    output logic irq_req_q,
    output ivp_pkg::ivp_slot_t vec_trap_q,
    output ivp_pkg::ivp_off_t vec_offset_q,
    output ivp_pkg::ivp_slot_t vec_rank_q
);

    // Hardware pending flags, one per slot
    ivp_pkg::ivp_vec_t pend_q;
    ivp_pkg::ivp_vec_t pend_d;
    // Software trap pending flags
    ivp_pkg::ivp_vec_t swp_q;
    ivp_pkg::ivp_vec_t swp_d;
    // Raw hardware requests by slot
    ivp_pkg::ivp_vec_t hw_req;
    // Software trap request by slot
    ivp_pkg::ivp_vec_t sw_req;
    // Slot cleared by this cycle's acknowledge
    ivp_pkg::ivp_vec_t ack_vec;
    // Requests allowed to compete
    ivp_pkg::ivp_vec_t elig_d;
    // Winning slot and its rank
    ivp_pkg::ivp_slot_t win_slot;
    ivp_pkg::ivp_slot_t win_rank;
    logic win_any;

    // Fixed rank of each slot
    function automatic ivp_pkg::ivp_slot_t ivp_rank(input ivp_pkg::ivp_slot_t s);
        ivp_pkg::ivp_slot_t r;
        r = s;
        unique case (s)
            `IVP_SLOT_EXT0: r = `IVP_RANK_EXT0;
            `IVP_SLOT_EXT2: r = `IVP_RANK_EXT2;
            `IVP_SLOT_TMR0: r = `IVP_RANK_TMR0;
            `IVP_SLOT_S0RX: r = `IVP_RANK_S0RX;
            `IVP_SLOT_S1RX: r = `IVP_RANK_S1RX;
            `IVP_SLOT_S1TX: r = `IVP_RANK_S1TX;
            `IVP_SLOT_PLL: r = `IVP_RANK_PLL;
            `IVP_SLOT_DMA1: r = `IVP_RANK_DMA1;
            `IVP_SLOT_HOST: r = `IVP_RANK_HOST;
            `IVP_SLOT_EXT3: r = `IVP_RANK_EXT3;
            `IVP_SLOT_S2RX: r = `IVP_RANK_S2RX;
            `IVP_SLOT_S2TX: r = `IVP_RANK_S2TX;
            `IVP_SLOT_DMA4: r = `IVP_RANK_DMA4;
            `IVP_SLOT_DMA5: r = `IVP_RANK_DMA5;
            `IVP_SLOT_EXT1: r = `IVP_RANK_EXT1;
            `IVP_SLOT_S0TX: r = `IVP_RANK_S0TX;
            `IVP_SLOT_DMA0: r = `IVP_RANK_DMA0;
            `IVP_SLOT_SW19: r = `IVP_RANK_SW19;
            `IVP_SLOT_DMA2: r = `IVP_RANK_DMA2;
            `IVP_SLOT_DMA3: r = `IVP_RANK_DMA3;
            `IVP_SLOT_TMR1: r = `IVP_RANK_TMR1;
            `IVP_SLOT_TWI: r = `IVP_RANK_TWI;
            `IVP_SLOT_BUSERR: r = `IVP_RANK_BUSERR;
            `IVP_SLOT_DATALOG: r = `IVP_RANK_DATALOG;
            default: r = s; // Reset, NMI, RTOS, 27-31: rank equals slot
        endcase
        return r;
    endfunction

    // Lowest rank among a set of slots, for checking
    function automatic ivp_pkg::ivp_slot_t ivp_min_rank(input ivp_pkg::ivp_vec_t v);
        ivp_pkg::ivp_slot_t m;
        m = 5'h1F;
        for (int i = 0; i < `IVP_NUM_SLOTS; i++) begin
            if (v[i] && ivp_rank(5'(i)) < m) begin
                m = ivp_rank(5'(i));
            end
        end
        return m;
    endfunction

    // Byte offset of a slot from the vector base
    function automatic ivp_pkg::ivp_off_t ivp_offset(input ivp_pkg::ivp_slot_t s);
        return {s, `IVP_SLOT_SHIFT'(0)};
    endfunction

    // Map each hardware source onto its slot
    always_comb begin
        hw_req = '0;
        hw_req[`IVP_SLOT_RESET] = reset_req;
        hw_req[`IVP_SLOT_NMI] = nmi_irq;
        hw_req[`IVP_SLOT_BUSERR] = bus_error_irq;
        // Shared slot: watchdog only in timer mode
        hw_req[`IVP_SLOT_EXT3] = ext_irq_pin_three | (watchdog_irq & wdt_gp_mode);
        hw_req[`IVP_SLOT_S0RX] = serial_zero_rx_irq;
        hw_req[`IVP_SLOT_S0TX] = serial_zero_tx_irq;
        hw_req[`IVP_SLOT_S1RX] = serial_one_rx_irq;
        hw_req[`IVP_SLOT_S1TX] = serial_one_tx_irq;
        hw_req[`IVP_SLOT_S2RX] = serial_two_rx_irq;
        hw_req[`IVP_SLOT_S2TX] = serial_two_tx_irq;
        hw_req[`IVP_SLOT_DMA0] = dma_zero_irq;
        hw_req[`IVP_SLOT_DMA1] = dma_one_irq;
        hw_req[`IVP_SLOT_DMA2] = dma_two_irq;
        hw_req[`IVP_SLOT_DMA3] = dma_three_irq;
        hw_req[`IVP_SLOT_DMA4] = dma_four_irq;
        hw_req[`IVP_SLOT_DMA5] = dma_five_irq;
        hw_req[`IVP_SLOT_RTOS] = rtos_irq;
        hw_req[`IVP_SLOT_EXT0] = ext_irq_pin_zero;
        hw_req[`IVP_SLOT_EXT1] = ext_irq_pin_one;
        hw_req[`IVP_SLOT_EXT2] = ext_irq_pin_two;
        hw_req[`IVP_SLOT_TMR0] = timer_zero_irq;
        hw_req[`IVP_SLOT_TMR1] = timer_one_irq;
        hw_req[`IVP_SLOT_PLL] = pll_lock_irq;
        hw_req[`IVP_SLOT_HOST] = host_irq;
        hw_req[`IVP_SLOT_TWI] = two_wire_bus_irq;
        hw_req[`IVP_SLOT_DATALOG] = data_log_irq;
        // Slots 19 and 27-31 stay without a hardware source
    end

    // Software trap and acknowledge decode
    always_comb begin
        sw_req = '0;
        ack_vec = '0;
        // Trap n lands in the same slot as hardware source n
        if (software_trap) begin
            sw_req[software_trap_num] = 1'b1;
        end
        // Acknowledge clears the slot being presented
        if (int_ack && irq_req_q) begin
            ack_vec[vec_trap_q] = 1'b1;
        end
    end

    // Next pending state: set wins over clear
    always_comb begin
        pend_d = (pend_q & ~ack_vec) | hw_req;
        swp_d = (swp_q & ~ack_vec) | sw_req;
        // Masks gate maskable hardware sources only
        elig_d = (pend_d & ((irq_enable & {`IVP_NUM_SLOTS{global_enable}})
            | `IVP_UNMASKABLE)) | swp_d;
    end

    // Pick the eligible slot of lowest rank
    always_comb begin
        win_any = 1'b0;
        win_slot = '0;
        win_rank = '0;
        for (int i = 0; i < `IVP_NUM_SLOTS; i++) begin
            // Strictly lower rank replaces the current choice
            if (elig_d[i] && (!win_any || ivp_rank(5'(i)) < win_rank)) begin
                win_any = 1'b1;
                win_slot = 5'(i);
                win_rank = ivp_rank(5'(i));
            end
        end
    end

    // Pending flag registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pend_q <= '0;
            swp_q <= '0;
        end else begin
            pend_q <= pend_d;
            swp_q <= swp_d;
        end
    end

    // Presented vector registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_req_q <= 1'b0;
            vec_trap_q <= '0;
            vec_offset_q <= '0;
            vec_rank_q <= '0;
        end else begin
            irq_req_q <= win_any;
            vec_trap_q <= win_slot;
            vec_offset_q <= ivp_offset(win_slot);
            vec_rank_q <= win_rank;
        end
    end

    // Eligible set seen by the last decision, for checking
    ivp_pkg::ivp_vec_t elig_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            elig_q <= '0;
        end else begin
            elig_q <= elig_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Offset tracks slot
    a_offset_slot: assert property (
        irq_req_q |-> vec_offset_q == {vec_trap_q, `IVP_SLOT_SHIFT'(0)})
        else $error("vector offset not eight bytes per slot");
    // Winner has lowest rank
    a_lowest_rank: assert property (
        irq_req_q |-> vec_rank_q == ivp_min_rank(elig_q))
        else $error("presented rank is not the lowest");
    // Reset overrides
    a_reset_wins: assert property (
        reset_req |=> irq_req_q && vec_trap_q == `IVP_SLOT_RESET && vec_offset_q == '0)
        else $error("reset request not presented in slot zero");
    // NMI unmaskable, bus error rank
    a_nmi_bus_error: assert property (
        (nmi_irq && !elig_d[`IVP_SLOT_RESET] |=> vec_trap_q == `IVP_SLOT_NMI)
        and (vec_trap_q == `IVP_SLOT_BUSERR |-> vec_rank_q == `IVP_RANK_BUSERR))
        else $error("nmi or bus error slot wrong");
    // Shared slot from pin three
    a_shared_slot: assert property (
        ext_irq_pin_three |=> pend_q[`IVP_SLOT_EXT3]
        && (vec_trap_q != `IVP_SLOT_EXT3 || vec_rank_q == `IVP_RANK_EXT3))
        else $error("pin three did not reach shared slot");
    // Watchdog blocked outside timer mode
    a_wdt_gate: assert property (
        watchdog_irq && !wdt_gp_mode && !ext_irq_pin_three
        && !pend_q[`IVP_SLOT_EXT3] |=> !pend_q[`IVP_SLOT_EXT3])
        else $error("watchdog raised slot outside timer mode");
    // Serial zero slots
    a_serial_zero: assert property (
        (serial_zero_rx_irq |=> pend_q[`IVP_SLOT_S0RX])
        and (serial_zero_tx_irq |=> pend_q[`IVP_SLOT_S0TX]))
        else $error("serial zero slot not set");
    // Serial one slots
    a_serial_one: assert property (
        (serial_one_rx_irq |=> pend_q[`IVP_SLOT_S1RX])
        and (serial_one_tx_irq |=> pend_q[`IVP_SLOT_S1TX]))
        else $error("serial one slot not set");
    // Serial two slots
    a_serial_two: assert property (
        (serial_two_rx_irq |=> pend_q[`IVP_SLOT_S2RX])
        and (serial_two_tx_irq |=> pend_q[`IVP_SLOT_S2TX]))
        else $error("serial two slot not set");
    // DMA zero and one slots
    a_dma_low: assert property (
        (dma_zero_irq |=> pend_q[`IVP_SLOT_DMA0]) and (dma_one_irq |=> pend_q[`IVP_SLOT_DMA1]))
        else $error("dma zero or one slot not set");
    // DMA two and three slots
    a_dma_mid: assert property (
        (dma_two_irq |=> pend_q[`IVP_SLOT_DMA2]) and (dma_three_irq |=> pend_q[`IVP_SLOT_DMA3]))
        else $error("dma two or three slot not set");
    // DMA four and five slots
    a_dma_high: assert property (
        (dma_four_irq |=> pend_q[`IVP_SLOT_DMA4]) and (dma_five_irq |=> pend_q[`IVP_SLOT_DMA5]))
        else $error("dma four or five slot not set");
    // RTOS slot and rank
    a_rtos_slot: assert property (
        rtos_irq |=> pend_q[`IVP_SLOT_RTOS] ##0 (vec_trap_q != `IVP_SLOT_RTOS
        || vec_rank_q == `IVP_SLOT_RTOS))
        else $error("rtos slot wrong");
    // Software-only slots
    a_sw_only: assert property (
        !pend_q[`IVP_SLOT_SW19] && pend_q[31:27] == '0)
        else $error("hardware pending in software-only slot");
    // Pin zero, host and data log slots
    a_other_src: assert property (
        (ext_irq_pin_zero |=> pend_q[`IVP_SLOT_EXT0]) and (host_irq |=> pend_q[`IVP_SLOT_HOST])
        and (data_log_irq |=> pend_q[`IVP_SLOT_DATALOG]))
        else $error("source did not reach its slot");
    // Pending clears only by acknowledge
    a_pend_hold: assert property (
        |($past(pend_q) & ~pend_q) |-> $past(int_ack) && $past(irq_req_q))
        else $error("pending flag lost without acknowledge");

    // Main scenarios
    c_nmi_taken: cover property (nmi_irq ##1 irq_req_q && vec_trap_q == `IVP_SLOT_NMI);
    c_sw19_taken: cover property (irq_req_q && vec_trap_q == `IVP_SLOT_SW19);
    c_ack_and_set: cover property (int_ack && irq_req_q && |(hw_req & ack_vec));
    c_wdt_shared: cover property (watchdog_irq && wdt_gp_mode ##1 pend_q[`IVP_SLOT_EXT3]);

endmodule

/* File: ivp_defines.svh */
// Constants for the interrupt vector priority unit
`ifndef IVP_DEFINES_SVH
`define IVP_DEFINES_SVH

// Slot size in bytes as a shift
`define IVP_SLOT_SHIFT 3
// Number of trap slots
`define IVP_NUM_SLOTS 32
// Reset and NMI cannot be masked
`define IVP_UNMASKABLE 32'h0000_0003

// Trap slot of each hardware source, and software-only slot 19
`define IVP_SLOT_RESET 5'h00
`define IVP_SLOT_NMI 5'h01
`define IVP_SLOT_EXT0 5'h02
`define IVP_SLOT_EXT2 5'h03
`define IVP_SLOT_TMR0 5'h04
`define IVP_SLOT_S0RX 5'h05
`define IVP_SLOT_S1RX 5'h06
`define IVP_SLOT_S1TX 5'h07
`define IVP_SLOT_PLL 5'h08
`define IVP_SLOT_DMA1 5'h09
`define IVP_SLOT_HOST 5'h0A
`define IVP_SLOT_EXT3 5'h0B
`define IVP_SLOT_S2RX 5'h0C
`define IVP_SLOT_S2TX 5'h0D
`define IVP_SLOT_DMA4 5'h0E
`define IVP_SLOT_DMA5 5'h0F
`define IVP_SLOT_EXT1 5'h10
`define IVP_SLOT_S0TX 5'h11
`define IVP_SLOT_DMA0 5'h12
`define IVP_SLOT_SW19 5'h13
`define IVP_SLOT_DMA2 5'h14
`define IVP_SLOT_DMA3 5'h15
`define IVP_SLOT_TMR1 5'h16
`define IVP_SLOT_TWI 5'h17
`define IVP_SLOT_BUSERR 5'h18
`define IVP_SLOT_DATALOG 5'h19
`define IVP_SLOT_RTOS 5'h1A

// Rank of each slot other than reset, NMI, RTOS and 27-31
`define IVP_RANK_EXT0 5'h03
`define IVP_RANK_EXT2 5'h05
`define IVP_RANK_TMR0 5'h06
`define IVP_RANK_S0RX 5'h07
`define IVP_RANK_S1RX 5'h09
`define IVP_RANK_S1TX 5'h0A
`define IVP_RANK_PLL 5'h0B
`define IVP_RANK_DMA1 5'h0D
`define IVP_RANK_HOST 5'h0E
`define IVP_RANK_EXT3 5'h0F
`define IVP_RANK_S2RX 5'h11
`define IVP_RANK_S2TX 5'h12
`define IVP_RANK_DMA4 5'h15
`define IVP_RANK_DMA5 5'h16
`define IVP_RANK_EXT1 5'h04
`define IVP_RANK_S0TX 5'h08
`define IVP_RANK_DMA0 5'h0C
`define IVP_RANK_SW19 5'h10
`define IVP_RANK_DMA2 5'h13
`define IVP_RANK_DMA3 5'h14
`define IVP_RANK_TMR1 5'h17
`define IVP_RANK_TWI 5'h18
`define IVP_RANK_BUSERR 5'h02
`define IVP_RANK_DATALOG 5'h19

`endif

/* File: ivp_pkg.sv */
// Types shared by the interrupt vector priority unit
package ivp_pkg;
    // Trap slot number or priority rank
    typedef logic [4:0] ivp_slot_t;
    // One bit per trap slot
    typedef logic [31:0] ivp_vec_t;
    // Byte offset from the vector base
    typedef logic [7:0] ivp_off_t;
endpackage

/* File: ivp_core_mdl.sv */
// Processor core model that acknowledges presented vectors
`timescale 1ns/1ps

module ivp_core_mdl (
    input wire logic sys_clk,
    input wire logic irq_req_q,
    input wire ivp_pkg::ivp_slot_t vec_trap_q,
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    output logic int_ack,
    output ivp_pkg::ivp_slot_t ack_trap,
    output logic [7:0] ack_cnt
);
    // Cycles spent waiting before answering
    logic [3:0] wait_cnt;

    // Quiet start
    initial begin
        int_ack = 1'b0;
        ack_trap = 5'h00;
        ack_cnt = 8'h00;
        wait_cnt = 4'h0;
    end

    // Acknowledge pulse, one cycle, after a chosen wait
    always @(negedge sys_clk) begin
        if (int_ack) begin
            // Release after the single taken edge
            int_ack <= 1'b0;
        end else if (ack_en && irq_req_q === 1'b1) begin
            if (wait_cnt + 4'h1 >= ack_delay) begin
                // Take the vector now presented
                int_ack <= 1'b1;
                ack_trap <= vec_trap_q;
                ack_cnt <= ack_cnt + 8'h01;
                wait_cnt <= 4'h0;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end else begin
            wait_cnt <= 4'h0;
        end
    end
endmodule

/* File: ivp_unit_tb.sv */
// Self-checking bench for the interrupt vector priority unit
`timescale 1ns/1ps

module ivp_unit_tb;
    // Clock, reset and stimulus
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [26:0] src = 27'h0;
    logic wdt_gp_mode = 1'b1;
    logic software_trap = 1'b0;
    ivp_pkg::ivp_slot_t software_trap_num = 5'h00;
    ivp_pkg::ivp_vec_t irq_enable = 32'hFFFF_FFFF;
    logic global_enable = 1'b1;
    logic ack_en = 1'b1;
    logic [3:0] ack_delay = 4'h1;
    // Outputs and model observations
    logic int_ack, irq_req_q;
    ivp_pkg::ivp_slot_t vec_trap_q, vec_rank_q, ack_trap;
    ivp_pkg::ivp_off_t vec_offset_q;
    logic [7:0] ack_cnt;
    // Counters
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    // Rank of each slot
    ivp_pkg::ivp_slot_t rank_tab [0:31] = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h06, 5'h07, 5'h09,
        5'h0A, 5'h0B, 5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h12, 5'h15, 5'h16, 5'h04, 5'h08, 5'h0C,
        5'h10, 5'h13, 5'h14, 5'h17, 5'h18, 5'h02, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E,
        5'h1F};
    // Slot of each hardware source, in src bit order
    ivp_pkg::ivp_slot_t src_slot [0:26] = '{5'h00, 5'h01, 5'h02, 5'h10, 5'h03, 5'h0B,
        5'h0B, 5'h04, 5'h16, 5'h05, 5'h11, 5'h06, 5'h07, 5'h0C, 5'h0D, 5'h12, 5'h09, 5'h14,
        5'h15, 5'h0E, 5'h0F, 5'h08, 5'h0A, 5'h17, 5'h18, 5'h19, 5'h1A};

    // Clock at 50 ns period
    always #25 sys_clk = ~sys_clk;

    ivp_unit dut (.sys_clk(sys_clk), .rst_b(rst_b), .reset_req(src[0]), .nmi_irq(src[1]),
        .ext_irq_pin_zero(src[2]), .ext_irq_pin_one(src[3]), .ext_irq_pin_two(src[4]),
        .ext_irq_pin_three(src[5]), .watchdog_irq(src[6]), .wdt_gp_mode(wdt_gp_mode),
        .timer_zero_irq(src[7]), .timer_one_irq(src[8]), .serial_zero_rx_irq(src[9]),
        .serial_zero_tx_irq(src[10]), .serial_one_rx_irq(src[11]),
        .serial_one_tx_irq(src[12]), .serial_two_rx_irq(src[13]),
        .serial_two_tx_irq(src[14]), .dma_zero_irq(src[15]), .dma_one_irq(src[16]),
        .dma_two_irq(src[17]), .dma_three_irq(src[18]), .dma_four_irq(src[19]),
        .dma_five_irq(src[20]), .pll_lock_irq(src[21]), .host_irq(src[22]),
        .two_wire_bus_irq(src[23]), .bus_error_irq(src[24]), .data_log_irq(src[25]),
        .rtos_irq(src[26]), .software_trap(software_trap),
        .software_trap_num(software_trap_num), .irq_enable(irq_enable),
        .global_enable(global_enable), .int_ack(int_ack), .irq_req_q(irq_req_q),
        .vec_trap_q(vec_trap_q), .vec_offset_q(vec_offset_q), .vec_rank_q(vec_rank_q));

    ivp_core_mdl core (.sys_clk(sys_clk), .irq_req_q(irq_req_q), .vec_trap_q(vec_trap_q),
        .ack_en(ack_en), .ack_delay(ack_delay), .int_ack(int_ack), .ack_trap(ack_trap),
        .ack_cnt(ack_cnt));

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Presented vector must be this slot
    task automatic expect_vec(input ivp_pkg::ivp_slot_t s);
        chk({7'h00, irq_req_q}, 8'h01);
        chk({3'h0, vec_trap_q}, {3'h0, s});
        chk(vec_offset_q, {s, 3'h0});
        chk({3'h0, vec_rank_q}, {3'h0, rank_tab[s]});
    endtask

    // Core took this slot and nothing is left
    task automatic expect_ack(input ivp_pkg::ivp_slot_t s);
        @(negedge sys_clk);
        chk({7'h00, irq_req_q}, 8'h00);
        chk({3'h0, ack_trap}, {3'h0, s});
    endtask

    // Each hardware source alone, served and cleared
    task automatic t_sources();
        for (int i = 0; i < 27; i++) begin
            @(negedge sys_clk);
            src[i] = 1'b1;
            @(negedge sys_clk);
            src[i] = 1'b0;
            expect_vec(src_slot[i]);
            expect_ack(src_slot[i]);
        end
    endtask

    // All sources at once, drained by a slow core in rank order
    task automatic t_priority();
        logic [7:0] c0;
        int n;
        ack_en <= 1'b0;
        @(negedge sys_clk);
        src = 27'h7FF_FFFF;
        @(negedge sys_clk);
        src = 27'h0;
        ack_delay <= 4'h2;
        ack_en <= 1'b1;
        c0 = ack_cnt;
        for (logic [7:0] r = 8'h00; r < 8'h1B; r++) begin
            if (r != 8'h10) begin
                n = 0;
                while (ack_cnt === c0 && n < 12) begin
                    @(negedge sys_clk);
                    n++;
                end
                c0 = ack_cnt;
                chk({3'h0, rank_tab[ack_trap]}, r);
            end
        end
        repeat (3) @(negedge sys_clk);
        chk({7'h00, irq_req_q}, 8'h00);
        ack_delay <= 4'h1;
    endtask

    // Masked sources wait, unmaskable one passes
    task automatic t_masking();
        global_enable = 1'b0;
        irq_enable = 32'h0;
        src[16] = 1'b1;
        @(negedge sys_clk);
        src[16] = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({7'h00, irq_req_q}, 8'h00);
        src[1] = 1'b1;
        @(negedge sys_clk);
        src[1] = 1'b0;
        expect_vec(5'h01);
        expect_ack(5'h01);
        global_enable = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({7'h00, irq_req_q}, 8'h00);
        irq_enable = 32'h0000_0200;
        @(negedge sys_clk);
        expect_vec(5'h09);
        expect_ack(5'h09);
        irq_enable = 32'hFFFF_FFFF;
    endtask

    // Watchdog ignored unless in timer mode
    task automatic t_watchdog();
        wdt_gp_mode = 1'b0;
        src[6] = 1'b1;
        @(negedge sys_clk);
        src[6] = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({7'h00, irq_req_q}, 8'h00);
        wdt_gp_mode = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({7'h00, irq_req_q}, 8'h00);
    endtask

    // Request held across its acknowledge stays pending
    task automatic t_set_wins();
        logic [7:0] c0;
        c0 = ack_cnt;
        src[9] = 1'b1;
        @(negedge sys_clk);
        expect_vec(5'h05);
        @(negedge sys_clk);
        src[9] = 1'b0;
        expect_vec(5'h05);
        @(negedge sys_clk);
        expect_ack(5'h05);
        chk(ack_cnt - c0, 8'h02);
    endtask

    // Every software trap, with all enables cleared
    task automatic t_soft_traps();
        global_enable = 1'b0;
        irq_enable = 32'h0;
        for (int i = 0; i < 32; i++) begin
            @(negedge sys_clk);
            software_trap = 1'b1;
            software_trap_num = i[4:0];
            @(negedge sys_clk);
            software_trap = 1'b0;
            expect_vec(i[4:0]);
            expect_ack(i[4:0]);
        end
    endtask

    // Hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    // Main sequence
    initial begin
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
        chk({7'h00, irq_req_q}, 8'h00);
        chk({3'h0, vec_trap_q}, 8'h00);
        t_sources();
        t_priority();
        t_masking();
        t_watchdog();
        t_set_wins();
        t_soft_traps();
        close_out();
    end
endmodule
